// *** vdl_delay_line.sv ***
/*
 * Vector fixed delay line with a per-lane delta latency, a Wishbone control
 * slave and a two-entry output buffer.
 * Assumes upstream presents one lane vector per sample period and takes
 * the sample_take_o pulse as the moment its vector was consumed.
 */
// Function
// - Each sample appears at the output exactly the configured latency later.
// - Output keeps input type, width and rate; no conversion.
// - All stages start at zero; outputs are zero until data arrives.
// - Asserted clear returns every stage to zero on the clock edge.
// - Clear wins over the enable input when both are active.
// - Deasserted enable freezes all stages until reenabled or cleared.
// - Latency must be a non-negative whole number, else configuration is invalid.
// - Zero latency together with an enable input is an invalid configuration.
// - Zero latency passes input to output without storage.
// - Latency one uses a single register stage per bit.
// - Delay is a shift section of latency minus one plus an output register.
// - Latencies above one section cascade several section-plus-register segments.
// - Lane i delay is base plus delta times (i minus 1).
// - Delta must keep every lane delay non-negative.
// - A vector of lane_count samples is taken each period, lanes delayed independently.
// - Clear is an optional synchronous input sampled on the block clock.
`default_nettype none

module vdl_delay_line (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire vdl_pkg::vdl_vec_t data_i,
	input wire logic clear_i,
	input wire logic enable_i,
	output logic sample_take_o,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output vdl_pkg::vdl_vec_t out_data_o,
	output logic cfg_err_o,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [vdl_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	import vdl_pkg::*;

	// ----------------------------------------------------------------
	// Configuration checks
	// ----------------------------------------------------------------
	// A bad setup cannot stop elaboration here, so it is reported on a pin
	// and in the status register instead, and the line never advances.
	localparam bit LAT_OK = (BASE_LATENCY >= 0);
	localparam bit ZERO_OK = !(BASE_LATENCY == 0 && HAS_ENABLE);
	localparam bit DELTA_OK = (LANE_COUNT < 2) || (DELTA_LATENCY * (LANE_COUNT - 1) >= -BASE_LATENCY);
	localparam bit CFG_OK = LAT_OK && ZERO_OK && DELTA_OK;

	// Delay of a lane counted from zero; used by stage gating and tap select.
	function automatic int lane_delay(input int lane);
		lane_delay = BASE_LATENCY + DELTA_LATENCY * lane;
	endfunction : lane_delay

	// Last stage of each section is the registered output of that section.
	function automatic bit is_seg_reg(input int stage);
		is_seg_reg = ((stage + 1) % SEG_LEN) == 0;
	endfunction : is_seg_reg

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [STAGE_N-1:0][LANE_COUNT-1:0][DATA_W-1:0] stage;
		vdl_vec_t [1:0] buf_data;
		logic [1:0] buf_cnt;
		logic [DIV_W-1:0] div;
		logic hold;
		logic sw_clear;
		logic [15:0] steps;
		vdl_wb_rsp_t wb;
	} vdl_state_t;

	vdl_state_t state_ff;
	vdl_state_t nxt_state;

	vdl_wb_req_t req;
	vdl_vec_t tap;
	logic sample_ce;
	logic clear_now;
	logic enable_now;
	logic buf_full;
	logic step;
	logic pop;
	logic [31:0] status_word;
	logic [31:0] config_word;

	// ----------------------------------------------------------------
	// Sample-rate enable and step decision
	// ----------------------------------------------------------------
	assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};
	assign sample_ce = (state_ff.div == DIV_LAST);
	// Clear is taken on any clock edge it is seen, not only on sample edges.
	assign clear_now = (HAS_CLEAR & clear_i) | state_ff.sw_clear;
	assign enable_now = (~HAS_ENABLE | enable_i) & ~state_ff.hold;
	assign buf_full = (state_ff.buf_cnt == 2'd2);
	assign pop = out_valid_o & out_ready_i;
	// A full buffer stalls the line exactly like a low enable, so no word is lost.
	assign step = CFG_OK & sample_ce & enable_now & ~buf_full & ~clear_now;
	assign sample_take_o = step;

	// ----------------------------------------------------------------
	// Lane taps
	// ----------------------------------------------------------------
	genvar gl;
	generate
		for (gl = 0; gl < LANE_COUNT; gl++) begin : g_tap
			localparam int D = lane_delay(gl);
			if (D == 0) begin : g_wire
				assign tap[gl] = data_i[gl];
			end else begin : g_reg
				assign tap[gl] = state_ff.stage[D-1][gl];
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Register words
	// ----------------------------------------------------------------
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[ST_CFG_OK_BIT] = CFG_OK;
		status_word[ST_FULL_BIT] = buf_full;
		status_word[ST_LEVEL_LSB +: 2] = state_ff.buf_cnt;
		status_word[ST_STEPS_LSB +: 16] = state_ff.steps;
		config_word = 32'h0000_0000;
		config_word[CFG_LANES_LSB +: 8] = 8'(LANE_COUNT);
		config_word[CFG_BASE_LSB +: 8] = 8'(BASE_LATENCY);
		config_word[CFG_DELTA_LSB +: 8] = 8'(DELTA_LATENCY);
		config_word[CFG_DEPTH_LSB +: 8] = 8'(STAGE_N);
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;

		// Divider that paces the sample-rate enable.
		if (sample_ce) begin
			nxt_state.div = DIV_RESET;
		end else begin
			nxt_state.div = state_ff.div + 8'h01;
		end

		// Delay stages: each lane only keeps the stages its delay needs.
		for (int l = 0; l < LANE_COUNT; l++) begin
			for (int k = 0; k < STAGE_N; k++) begin
				if (clear_now) begin
					nxt_state.stage[k][l] = '0;
				end else if (step && k < lane_delay(l)) begin
					// Section boundaries register the previous stage just as
					// interior stages do; the split only bounds each section.
					if (k == 0) begin
						nxt_state.stage[k][l] = data_i[l];
					end else if (is_seg_reg(k - 1)) begin
						nxt_state.stage[k][l] = state_ff.stage[k-1][l];
					end else begin
						nxt_state.stage[k][l] = state_ff.stage[k-1][l];
					end
				end
			end
		end

		// Two-entry output buffer, head at entry zero.
		unique case ({step, pop})
			2'b10: begin
				nxt_state.buf_data[state_ff.buf_cnt[0]] = tap;
				nxt_state.buf_cnt = state_ff.buf_cnt + 2'd1;
			end
			2'b01: begin
				nxt_state.buf_data[0] = state_ff.buf_data[1];
				nxt_state.buf_cnt = state_ff.buf_cnt - 2'd1;
			end
			2'b11: begin
				if (state_ff.buf_cnt == 2'd1) begin
					nxt_state.buf_data[0] = tap;
				end else begin
					nxt_state.buf_data[0] = state_ff.buf_data[1];
					nxt_state.buf_data[1] = tap;
				end
			end
			2'b00: begin
			end
		endcase

		if (step) begin
			nxt_state.steps = state_ff.steps + 16'h0001;
		end

		// Software clear lasts exactly one clock.
		nxt_state.sw_clear = 1'b0;

		// Wishbone slave: answer one cycle after the strobe, drop the next.
		nxt_state.wb.ack = req.cyc & req.stb & ~state_ff.wb.ack;
		nxt_state.wb.dat = RDATA_RESET;
		// A write lands on the edge at which the master sees ack high, so a
		// cycle abandoned before its ack changes nothing.
		if (req.cyc && req.stb && state_ff.wb.ack && req.we) begin
			if (req.adr == ADR_CTRL && req.sel[0]) begin
				nxt_state.sw_clear = req.dat[CTRL_CLEAR_BIT];
				nxt_state.hold = req.dat[CTRL_HOLD_BIT];
			end
		end
		if (req.cyc && req.stb && !state_ff.wb.ack && !req.we) begin
			unique case (req.adr)
				ADR_CTRL: nxt_state.wb.dat = {30'h0000_0000, state_ff.hold, 1'b0};
				ADR_STATUS: nxt_state.wb.dat = status_word;
				ADR_CONFIG: nxt_state.wb.dat = config_word;
				default: nxt_state.wb.dat = RDATA_RESET;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign out_valid_o = (state_ff.buf_cnt != 2'd0);
	assign out_data_o = state_ff.buf_data[0];
	assign cfg_err_o = ~CFG_OK;
	assign wb_ack_o = state_ff.wb.ack;
	assign wb_dat_o = state_ff.wb.dat;

endmodule : vdl_delay_line

`default_nettype wire

// *** vdl_delay_line_properties.sv ***
/* Port checker of the delay line: take spacing, stalls, clear and bus reply.
 * Assumes the single block clock and its synchronous active-low reset. */
`default_nettype none
module vdl_delay_line_properties (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic clear_i,
	input wire logic enable_i,
	input wire logic sample_take_o,
	input wire logic out_valid_o,
	input wire logic out_ready_i,
	input wire vdl_pkg::vdl_vec_t out_data_o,
	input wire logic cfg_err_o,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	take_gap_a: assert property (sample_take_o |=> !sample_take_o [*3]) else $error("takes too close");
	first_take_a: assert property ($rose(rst_n_i) |-> !sample_take_o [*3]) else $error("early take");
	hold_off_a: assert property (!enable_i |-> !sample_take_o) else $error("take while disabled");
	clear_wins_a: assert property (clear_i |-> !sample_take_o) else $error("take during clear");
	reset_empty_a: assert property ($rose(rst_n_i) |-> !out_valid_o && out_data_o == '0) else $error("not zero");
	out_hold_a: assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
		else $error("stalled word changed");
	push_shows_a: assert property (sample_take_o && !out_valid_o |=> out_valid_o) else $error("push lost");
	cfg_ok_a: assert property (rst_n_i |-> !cfg_err_o) else $error("valid setup flagged");
	ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("late ack");
	rdata_idle_a: assert property (!wb_ack_o |-> wb_dat_o == '0) else $error("read data without ack");
	cover property (sample_take_o);
	cover property (out_valid_o && !out_ready_i [*8]);
	cover property (clear_i && !enable_i);
endmodule : vdl_delay_line_properties
bind vdl_delay_line vdl_delay_line_properties u_props (.clock_i, .rst_n_i, .clear_i, .enable_i, .sample_take_o,
	.out_valid_o, .out_ready_i, .out_data_o, .cfg_err_o, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o);
`default_nettype wire

// *** vdl_delay_line_tb.sv ***
/* Self-checking bench of the delay line: random lanes, clear, stalls, bus.
 * Assumes the package setup and the sink model beside it. */
`default_nettype none
module vdl_delay_line_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import vdl_pkg::*;
	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic clear_i = 1'b0;
	logic enable_i = 1'b0;
	logic stall = 1'b0;
	logic sample_take_o, out_valid_o, out_ready_i, cfg_err_o, wb_ack_o;
	logic [31:0] wb_dat_o, rd;
	vdl_wb_req_t req = '0;
	vdl_vec_t data_i = '0;
	vdl_vec_t out_data_o;
	vdl_vec_t hist[$];
	vdl_vec_t exp_q[$];
	integer seed = 32'h4676E1A4;
	integer mismatches = 0;
	integer n_tests = 0;
	always #2.5 clock_i = ~clock_i;
	vdl_delay_line u_dut (.clock_i, .rst_n_i, .data_i, .clear_i, .enable_i, .sample_take_o, .out_valid_o,
		.out_ready_i, .out_data_o, .cfg_err_o, .wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_we_i(req.we),
		.wb_sel_i(req.sel), .wb_adr_i(req.adr), .wb_dat_i(req.dat), .wb_dat_o, .wb_ack_o);
	vdl_sink_model u_sink (.clock_i, .rst_n_i, .stall_i(stall), .ready_o(out_ready_i));
	task automatic cmp(input logic [63:0] got, input logic [63:0] want, input string m);
		n_tests++;
		if (got !== want) begin
			mismatches++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask : cmp
	task automatic final_report();
		if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : final_report
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hF, adr: a, dat: d};
		do begin
			@(posedge clock_i);
			k++;
		end while (!wb_ack_o && k < 64);
		rd = wb_dat_o;
		req <= '0;
		@(posedge clock_i);
		if (k >= 64) begin
			mismatches++;
			final_report();
		end
	endtask : wb
	// Lane i repeats the vector taken delay(i) takes earlier, zero before that.
	function automatic vdl_vec_t expect_word();
		vdl_vec_t w;
		int d;
		for (int i = 0; i < LANE_COUNT; i++) begin
			d = BASE_LATENCY + DELTA_LATENCY * i;
			w[i] = (hist.size() >= d) ? hist[hist.size() - d][i] : '0;
		end
		return w;
	endfunction : expect_word
	always @(posedge clock_i) begin
		data_i <= {$random(seed), $random(seed)};
		if (!rst_n_i) begin
			hist.delete();
			exp_q.delete();
		end else begin
			if (out_valid_o && out_ready_i) cmp(out_data_o, exp_q.size() ? exp_q.pop_front() : 'x, "lane data");
			if (clear_i) hist.delete();
			else if (sample_take_o) begin
				exp_q.push_back(expect_word());
				hist.push_back(data_i);
			end
		end
	end
	initial begin
		repeat (16) @(posedge clock_i);
		rst_n_i <= 1'b1;
		enable_i <= 1'b1;
		wb(1'b0, ADR_CONFIG, 32'h0);
		cmp(rd, 32'h0A03_0104, "config word");
		wb(1'b1, 8'h0C, 32'hFFFF_FFFF);
		wb(1'b0, 8'h0C, 32'h0);
		cmp(rd, 32'h0, "unmapped read");
		wb(1'b0, ADR_STATUS, 32'h0);
		cmp(rd[0], 1'b1, "config ok");
		cmp(cfg_err_o, 1'b0, "setup flagged");
		repeat (300) begin
			@(posedge clock_i);
			enable_i <= ($random(seed) % 8 != 0);
			clear_i <= ($random(seed) % 40 == 0);
		end
		// Every enable and clear pairing, clear with enable low included.
		for (int c = 0; c < 4; c++) begin
			@(posedge clock_i);
			{enable_i, clear_i} <= 2'(c);
			repeat (8) @(posedge clock_i);
		end
		enable_i <= 1'b1;
		clear_i <= 1'b0;
		stall <= 1'b1;
		repeat (60) @(posedge clock_i);
		wb(1'b0, ADR_STATUS, 32'h0);
		cmp(rd[3:1], 3'b101, "buffer full");
		cmp(sample_take_o, 1'b0, "take while full");
		stall <= 1'b0;
		wb(1'b1, ADR_CTRL, 32'h2);
		repeat (8) begin
			@(posedge clock_i);
			cmp(sample_take_o, 1'b0, "take while held");
		end
		wb(1'b0, ADR_CTRL, 32'h0);
		cmp(rd, 32'h2, "control readback");
		wb(1'b1, ADR_CTRL, 32'h0);
		repeat (200) @(posedge clock_i);
		// Software clear while the line is frozen, then a reset in mid-run.
		enable_i <= 1'b0;
		repeat (4) @(posedge clock_i);
		wb(1'b1, ADR_CTRL, 32'h1);
		hist.delete();
		enable_i <= 1'b1;
		repeat (100) @(posedge clock_i);
		rst_n_i <= 1'b0;
		repeat (3) @(posedge clock_i);
		rst_n_i <= 1'b1;
		repeat (100) @(posedge clock_i);
		enable_i <= 1'b0;
		for (int k = 0; k < 400 && exp_q.size() > 0; k++) @(posedge clock_i);
		cmp(exp_q.size(), 0, "words left undelivered");
		final_report();
	end
endmodule : vdl_delay_line_tb
`default_nettype wire

// *** vdl_pkg.sv ***
/*
 * Package of the vector fixed delay line: lane geometry, latency setup,
 * register map of the control slave, reset values and cycle counts.
 * Assumes one 200 MHz clock and a sample rate derived from it by a divider.
 */
`default_nettype none

package vdl_pkg;

	// ----------------------------------------------------------------
	// Lane geometry and latency setup
	// ----------------------------------------------------------------
	localparam int LANE_COUNT = 4;
	localparam int DATA_W = 16;
	localparam int BASE_LATENCY = 1;
	localparam int DELTA_LATENCY = 3;
	localparam bit HAS_ENABLE = 1'b1;
	localparam bit HAS_CLEAR = 1'b1;
	// Longest span of one shift section plus its output register.
	localparam int SEG_LEN = 32;

	localparam int LAST_LANE_DELAY = BASE_LATENCY + DELTA_LATENCY * (LANE_COUNT - 1);
	localparam int MAX_DELAY = (LAST_LANE_DELAY > BASE_LATENCY) ? LAST_LANE_DELAY : BASE_LATENCY;
	localparam int STAGE_N = (MAX_DELAY > 0) ? MAX_DELAY : 1;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLOCK_MHZ = 200;
	localparam int SAMPLE_PERIOD_NS = 20;
	localparam int CLK_PER_SAMPLE = (SAMPLE_PERIOD_NS * CLOCK_MHZ) / 1000;
	localparam int DIV_W = 8;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CLK_PER_SAMPLE - 1);
	localparam logic [DIV_W-1:0] DIV_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Register map, byte addresses on a 32-bit bus
	// ----------------------------------------------------------------
	localparam int ADR_W = 8;
	localparam logic [ADR_W-1:0] ADR_CTRL = 8'h00;
	localparam logic [ADR_W-1:0] ADR_STATUS = 8'h04;
	localparam logic [ADR_W-1:0] ADR_CONFIG = 8'h08;
	localparam int CTRL_CLEAR_BIT = 0;
	localparam int CTRL_HOLD_BIT = 1;
	localparam int ST_CFG_OK_BIT = 0;
	localparam int ST_FULL_BIT = 1;
	localparam int ST_LEVEL_LSB = 2;
	localparam int ST_STEPS_LSB = 16;
	localparam int CFG_LANES_LSB = 0;
	localparam int CFG_BASE_LSB = 8;
	localparam int CFG_DELTA_LSB = 16;
	localparam int CFG_DEPTH_LSB = 24;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
	localparam logic [15:0] STEPS_RESET = 16'h0000;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef logic [LANE_COUNT-1:0][DATA_W-1:0] vdl_vec_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [ADR_W-1:0] adr;
		logic [31:0] dat;
	} vdl_wb_req_t;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} vdl_wb_rsp_t;

endpackage : vdl_pkg

`default_nettype wire

// *** vdl_sink_model.sv ***
/* Downstream sink model for the delay line output stream.
 * Assumes one clock; stall_i forces a long refusal. */
`default_nettype none
module vdl_sink_model (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic stall_i,
	output logic ready_o
);
	timeunit 1ns;
	timeprecision 1ps;
	integer seed = 32'h1357_9BDF;
	logic ready_ff = 1'b0;
	// Ready drops at random so the buffer is exercised, not only when stalled.
	always @(posedge clock_i) begin
		ready_ff <= rst_n_i && !stall_i && ($random(seed) % 4 != 0);
	end
	assign ready_o = ready_ff;
endmodule : vdl_sink_model
`default_nettype wire
